// ===== rtl/css_edge_monitor.sv
// main clock activity monitor
// assumes osc_level is already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module css_edge_monitor #(
	parameter int WIN = css_pkg::MON_WIN_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// sampled oscillator
	input  wire logic osc_level,
	// state
	output logic      stopped_q,
	output logic      stop_evt_q,
	output logic      restart_evt_q
);
	logic [7:0] cnt_q;
	logic       last_q;
	logic       edge_w;

	assign edge_w = osc_level ^ last_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			last_q        <= 1'b0;
			cnt_q         <= 8'h00;
			stopped_q     <= 1'b0;
			stop_evt_q    <= 1'b0;
			restart_evt_q <= 1'b0;
		end else begin
			last_q        <= osc_level;
			stop_evt_q    <= 1'b0;
			restart_evt_q <= 1'b0;
			if (edge_w) begin
				cnt_q <= 8'h00;
				if (stopped_q) begin
					stopped_q     <= 1'b0;
					restart_evt_q <= 1'b1;
				end
			end else if (cnt_q == 8'(WIN - 1)) begin
				if (!stopped_q) begin
					stopped_q  <= 1'b1;
					stop_evt_q <= 1'b1;
				end
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule // css_edge_monitor
`default_nettype wire

// ===== rtl/css_pkg.sv
// constants for the clock source supervisor
// assumes a single clk_sys domain and byte-wide register port
package css_pkg;
	// ************
	// register indices
	// ************
	localparam logic [3:0] ADDR_PROTECT  = 4'h0;
	localparam logic [3:0] ADDR_CLK_CTL0 = 4'h1;
	localparam logic [3:0] ADDR_CLK_CTL1 = 4'h2;
	localparam logic [3:0] ADDR_OSC_DET  = 4'h3;
	localparam logic [3:0] ADDR_PROC_M2  = 4'h4;
	localparam logic [3:0] ADDR_PLL_CTL  = 4'h5;
	localparam logic [3:0] ADDR_STATUS   = 4'h6;
	// ************
	// field positions
	// ************
	// protect_register
	localparam int PRT_CLK  = 0;
	localparam int PRT_PMOD = 1;
	// clock_control_0
	localparam int C0_GATE  = 2;
	localparam int C0_MSTOP = 5;
	localparam int C0_DIV8  = 6;
	localparam int C0_SUB   = 7;
	// clock_control_1
	localparam int C1_STOP  = 0;
	localparam int C1_PLL   = 1;
	localparam int C1_XDRV  = 5;
	localparam int C1_DIV0  = 6;
	// osc_detect_control
	localparam int OD_EN    = 0;
	localparam int OD_OCO   = 1;
	localparam int OD_FLAG  = 2;
	localparam int OD_MON   = 3;
	localparam int OD_ACT   = 7;
	// processor_mode_2
	localparam int PM_WAIT  = 0;
	localparam int PM_LOCK  = 1;
	localparam int PM_WDT   = 2;
	// pll_control
	localparam int PL_EN    = 7;
	// ************
	// reset values
	// ************
	localparam logic [7:0] RST_CLK_CTL0 = 8'h48;
	localparam logic [7:0] RST_CLK_CTL1 = 8'h20;
	localparam logic [7:0] RST_PLL_CTL  = 8'h01;
	localparam logic [1:0] RST_CPU_DIV  = 2'h2;
	// ************
	// timing
	// ************
	localparam int CLK_PERIOD_NS = 40;
	localparam int MON_WIN_NS    = 640;
	localparam int MON_WIN_CYC   = MON_WIN_NS / CLK_PERIOD_NS;
	// ************
	// types
	// ************
	typedef enum logic [1:0] {
		CSS_SRC_MAIN = 2'b00,
		CSS_SRC_SUB  = 2'b01,
		CSS_SRC_OCO  = 2'b10,
		CSS_SRC_PLL  = 2'b11
	} css_src_t;
endpackage : css_pkg

// ===== rtl/css_pll_mult.sv
// one-time pll multiplier latch
// assumes write qualification is done by the caller
`timescale 1ns/1ps
`default_nettype none
module css_pll_mult (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// write
	input  wire logic       wr,
	input  wire logic       pll_on,
	input  wire logic [2:0] wdata,
	// value
	output logic      [2:0] mult_q
);
	logic done_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mult_q <= css_pkg::RST_PLL_CTL[2:0];
			done_q <= 1'b0;
		end else if (wr && !pll_on && !done_q) begin // R18
			mult_q <= wdata;
			done_q <= 1'b1;
		end
	end
endmodule // css_pll_mult
`default_nettype wire

// ===== rtl/css_top.sv
// clock source supervisor: control registers, stop detection, lock
// assumes a register port synchronous to clk_sys and sampled osc pins
//
// Overview of operation
// R1 - stop with main source selects on-chip oscillator
// R2 - software keeps oscillator select while stopped
// R3 - flag sets on stop and restart
// R4 - interrupt only on flag rising
// R5 - flag clears only by writing zero
// R6 - no new interrupt while flag set
// R7 - handler rereads monitor bit several times
// R8 - pll source: no switch, interrupt only
// R9 - disable detection before stop mode
// R10 - disable detection before main stop
// R11 - detect reset keeps enable select action
// R12 - main stopped forces div8 and drive
// R13 - unlock protection before control writes
// R14 - pll wait select effective when pll on
// R15 - lock bit cannot be cleared
// R16 - lock freezes listed clock bits
// R17 - watchdog source on-chip, blocks stop
// R18 - multiplier written once while pll off
// R19 - prepare dividers before pll enable
// R20 - reset runs main divided by eight
// R21 - external clock stops only with sub
// R22 - wait sub stable before selecting
// R23 - oscillator select runs on-chip oscillator
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module css_top (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       det_resetn,
	// register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata_q,
	// oscillator
	input  wire logic       main_osc_in,
	input  wire logic       ext_clock_mode,
	// clock controls
	output logic      [1:0] cpu_src_q,
	output logic      [2:0] cpu_div_q,
	output logic            onchip_osc_on_q,
	output logic            main_osc_run_q,
	output logic            pll_on_q,
	output logic            stop_mode_q,
	output logic            wdt_onchip_q,
	output logic            wait_allowed_q,
	output logic            osc_irq_q
);
	// ************
	// registers
	// ************
	logic       clock_protect_unlock_q, procmode_protect_unlock_q;
	logic       periph_gate_in_sleep_q, main_osc_stop_q, div8_q, sub_clock_select_q;
	logic       stop_mode_request_q, pll_cpu_select_q, xin_drive_q;
	logic [1:0] cpu_divider_select_q;
	logic       osc_stop_detect_enable_q, onchip_osc_select_q, osc_detect_flag_q;
	logic       detect_action_select_q;
	logic       pll_wait_select_q, clock_change_lock_q, watchdog_source_onchip_q;
	logic       pll_enable_q;
	logic [2:0] pll_multiplier;
	logic       main_clock_monitor, stop_evt, restart_evt;
	logic       div8_select, xin_drive_high;
	logic       wr0, wr1, wr2, wr3, wr4, wr5, lock_ok;

	assign wr0     = wr && addr == css_pkg::ADDR_CLK_CTL0 && clock_protect_unlock_q; // R13
	assign wr1     = wr && addr == css_pkg::ADDR_CLK_CTL1 && clock_protect_unlock_q; // R13
	assign wr2     = wr && addr == css_pkg::ADDR_OSC_DET;
	assign wr4     = wr && addr == css_pkg::ADDR_PROC_M2 && procmode_protect_unlock_q; // R13
	assign wr5     = wr && addr == css_pkg::ADDR_PLL_CTL && clock_protect_unlock_q; // R13
	assign wr3     = wr && addr == css_pkg::ADDR_PROTECT;
	assign lock_ok = !clock_change_lock_q; // R16

	// forced bits while main stopped and on-chip oscillator off
	assign div8_select    = div8_q || (!onchip_osc_select_q && main_osc_stop_q); // R12
	assign xin_drive_high = xin_drive_q || (!onchip_osc_select_q && main_osc_stop_q); // R12

	// ************
	// submodules
	// ************
	css_edge_monitor u_mon (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.osc_level     (main_osc_in),
		.stopped_q     (main_clock_monitor),
		.stop_evt_q    (stop_evt),
		.restart_evt_q (restart_evt)
	);

	css_pll_mult u_mult (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.wr      (wr5 && lock_ok), // R16
		.pll_on  (pll_enable_q),
		.wdata   (wdata[2:0]),
		.mult_q  (pll_multiplier)
	);

	// ************
	// protection
	// ************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			clock_protect_unlock_q    <= 1'b0;
			procmode_protect_unlock_q <= 1'b0;
		end else if (wr3) begin
			clock_protect_unlock_q    <= wdata[css_pkg::PRT_CLK];
			procmode_protect_unlock_q <= wdata[css_pkg::PRT_PMOD];
		end
	end

	// ************
	// clock control 0 and 1
	// ************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			periph_gate_in_sleep_q <= css_pkg::RST_CLK_CTL0[css_pkg::C0_GATE];
			main_osc_stop_q        <= css_pkg::RST_CLK_CTL0[css_pkg::C0_MSTOP];
			div8_q                 <= css_pkg::RST_CLK_CTL0[css_pkg::C0_DIV8]; // R20
			sub_clock_select_q     <= css_pkg::RST_CLK_CTL0[css_pkg::C0_SUB];
		end else if (wr0) begin
			div8_q <= wdata[css_pkg::C0_DIV8];
			if (lock_ok) begin // R16
				periph_gate_in_sleep_q <= wdata[css_pkg::C0_GATE];
				main_osc_stop_q        <= wdata[css_pkg::C0_MSTOP];
				sub_clock_select_q     <= wdata[css_pkg::C0_SUB];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stop_mode_request_q  <= css_pkg::RST_CLK_CTL1[css_pkg::C1_STOP];
			pll_cpu_select_q     <= css_pkg::RST_CLK_CTL1[css_pkg::C1_PLL];
			xin_drive_q          <= css_pkg::RST_CLK_CTL1[css_pkg::C1_XDRV];
			cpu_divider_select_q <= css_pkg::RST_CPU_DIV;
		end else if (wr1) begin
			xin_drive_q          <= wdata[css_pkg::C1_XDRV];
			cpu_divider_select_q <= wdata[css_pkg::C1_DIV0 +: 2];
			if (lock_ok) begin // R16
				pll_cpu_select_q <= wdata[css_pkg::C1_PLL];
				if (!watchdog_source_onchip_q) // R17
					stop_mode_request_q <= wdata[css_pkg::C1_STOP];
			end
		end
	end

	// ************
	// oscillation stop detection
	// ************
	// bits kept across a detection reset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			osc_stop_detect_enable_q <= 1'b0;
			onchip_osc_select_q      <= 1'b0;
			detect_action_select_q   <= 1'b0;
		end else begin
			if (wr2 && clock_protect_unlock_q) begin
				if (lock_ok) // R16
					osc_stop_detect_enable_q <= wdata[css_pkg::OD_EN];
				onchip_osc_select_q    <= wdata[css_pkg::OD_OCO];
				detect_action_select_q <= wdata[css_pkg::OD_ACT];
			end
			if (stop_evt && osc_stop_detect_enable_q && detect_action_select_q
					&& !pll_cpu_select_q && !sub_clock_select_q) // R1 R8
				onchip_osc_select_q <= 1'b1;
		end
	end

	// flag and interrupt; cleared by detection reset as well
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			osc_detect_flag_q <= 1'b0;
			osc_irq_q         <= 1'b0;
		end else if (!det_resetn) begin // R11
			osc_detect_flag_q <= 1'b0;
			osc_irq_q         <= 1'b0;
		end else begin
			osc_irq_q <= 1'b0;
			if (osc_stop_detect_enable_q && (stop_evt || restart_evt)) begin
				osc_detect_flag_q <= 1'b1; // R3
				if (!osc_detect_flag_q && detect_action_select_q)
					osc_irq_q <= 1'b1; // R4 R6 R8
			end else if (wr2 && clock_protect_unlock_q && !wdata[css_pkg::OD_FLAG])
				osc_detect_flag_q <= 1'b0; // R5
		end
	end

	// ************
	// processor mode 2 and pll
	// ************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pll_wait_select_q        <= 1'b1;
			clock_change_lock_q      <= 1'b0;
			watchdog_source_onchip_q <= 1'b0;
		end else if (wr4) begin
			if (!pll_enable_q) // R14
				pll_wait_select_q <= wdata[css_pkg::PM_WAIT];
			if (wdata[css_pkg::PM_LOCK])
				clock_change_lock_q <= 1'b1; // R15
			if (wdata[css_pkg::PM_WDT])
				watchdog_source_onchip_q <= 1'b1; // R17
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			pll_enable_q <= 1'b0;
		else if (wr5 && lock_ok) // R16
			pll_enable_q <= wdata[css_pkg::PL_EN];
	end

	// ************
	// outputs
	// ************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpu_src_q       <= 2'h0;
			cpu_div_q       <= 3'h3;
			onchip_osc_on_q <= 1'b0;
			main_osc_run_q  <= 1'b1;
			pll_on_q        <= 1'b0;
			stop_mode_q     <= 1'b0;
			wdt_onchip_q    <= 1'b0;
			wait_allowed_q  <= 1'b1;
		end else begin
			if (sub_clock_select_q)
				cpu_src_q <= css_pkg::CSS_SRC_SUB;
			else if (onchip_osc_select_q)
				cpu_src_q <= css_pkg::CSS_SRC_OCO; // R23
			else if (pll_cpu_select_q)
				cpu_src_q <= css_pkg::CSS_SRC_PLL;
			else
				cpu_src_q <= css_pkg::CSS_SRC_MAIN;
			if (div8_select)
				cpu_div_q <= 3'h3; // R20
			else if (cpu_divider_select_q == 2'h0)
				cpu_div_q <= 3'h0;
			else
				cpu_div_q <= {1'b0, cpu_divider_select_q} + 3'h1;
			onchip_osc_on_q <= onchip_osc_select_q || watchdog_source_onchip_q; // R17 R23
			main_osc_run_q  <= !main_osc_stop_q
				|| (ext_clock_mode && !sub_clock_select_q); // R21
			pll_on_q       <= pll_enable_q;
			stop_mode_q    <= stop_mode_request_q;
			wdt_onchip_q   <= watchdog_source_onchip_q;
			wait_allowed_q <= !clock_change_lock_q; // R16
		end
	end

	// ************
	// read port
	// ************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rdata_q <= 8'h00;
		else if (rd) begin
			unique case (addr)
				css_pkg::ADDR_PROTECT:
					rdata_q <= {6'h00, procmode_protect_unlock_q, clock_protect_unlock_q};
				css_pkg::ADDR_CLK_CTL0:
					// unused bits read as their reset value
					rdata_q <= {sub_clock_select_q, div8_select, main_osc_stop_q,
						css_pkg::RST_CLK_CTL0[4:3], periph_gate_in_sleep_q,
						css_pkg::RST_CLK_CTL0[1:0]};
				css_pkg::ADDR_CLK_CTL1:
					rdata_q <= {cpu_divider_select_q, xin_drive_high, 3'h0,
						pll_cpu_select_q, stop_mode_request_q};
				css_pkg::ADDR_OSC_DET:
					rdata_q <= {detect_action_select_q, 3'h0, main_clock_monitor,
						osc_detect_flag_q, onchip_osc_select_q, osc_stop_detect_enable_q};
				css_pkg::ADDR_PROC_M2:
					rdata_q <= {5'h00, watchdog_source_onchip_q, clock_change_lock_q,
						pll_wait_select_q};
				css_pkg::ADDR_PLL_CTL:
					rdata_q <= {pll_enable_q, 4'h0, pll_multiplier};
				default:
					rdata_q <= 8'h00;
			endcase
		end
	end

	// ************
	// checks
	// ************
	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
		det_resetn && osc_stop_detect_enable_q && stop_evt |=> osc_detect_flag_q)
		else $error("flag not set on detection");
	AST_IRQ_EDGE: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
		osc_irq_q |-> osc_detect_flag_q && !$past(osc_detect_flag_q))
		else $error("irq without flag rising");
	AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
		osc_detect_flag_q && det_resetn && !wr2 |=> osc_detect_flag_q)
		else $error("flag cleared without write");
	AST_NO_REIRQ: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
		osc_detect_flag_q && det_resetn |=> !osc_irq_q)
		else $error("irq while flag set");
	AST_FALLBACK: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
		stop_evt && osc_stop_detect_enable_q && detect_action_select_q
		&& !pll_cpu_select_q && !sub_clock_select_q |=> onchip_osc_select_q)
		else $error("no fallback on stop");
	AST_LOCK_STICKY: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
		clock_change_lock_q |=> clock_change_lock_q)
		else $error("lock cleared");
	AST_LOCK_PLL: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
		clock_change_lock_q |=> $stable(pll_enable_q) && $stable(main_osc_stop_q))
		else $error("locked bit changed");
	AST_WDT_STOP: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
		watchdog_source_onchip_q && !stop_mode_request_q |=> !stop_mode_request_q)
		else $error("stop request taken");
	AST_FORCE_DIV8: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
		!onchip_osc_select_q && main_osc_stop_q |=> cpu_div_q == 3'h3)
		else $error("div8 not forced");
	COV_STOP_IRQ: cover property (@(posedge clk_sys) disable iff (!resetn)
		stop_evt ##1 osc_irq_q);
	COV_RESTART: cover property (@(posedge clk_sys) disable iff (!resetn) restart_evt);
	COV_LOCK: cover property (@(posedge clk_sys) disable iff (!resetn)
		$rose(clock_change_lock_q));
endmodule // css_top
`default_nettype wire

// ===== test/css_tb.sv
// self-checking bench for the clock source supervisor
// assumes css_top and css_pkg are compiled first; bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
	// ************
	// signals
	// ************
	logic       clk_sys;
	logic       resetn;
	logic       det_resetn;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata_q;
	logic       main_osc_in;
	logic       ext_clock_mode;
	logic [1:0] cpu_src_q;
	logic [2:0] cpu_div_q;
	logic       onchip_osc_on_q;
	logic       main_osc_run_q;
	logic       pll_on_q;
	logic       stop_mode_q;
	logic       wdt_onchip_q;
	logic       wait_allowed_q;
	logic       osc_irq_q;
	int         fail_count;
	int         checked;
	int         irq_count;
	int         osc_cnt;
	logic       osc_run;
	logic       rd_seen;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;

	css_top dut (
		.clk_sys(clk_sys), .resetn(resetn), .det_resetn(det_resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
		.main_osc_in(main_osc_in), .ext_clock_mode(ext_clock_mode),
		.cpu_src_q(cpu_src_q), .cpu_div_q(cpu_div_q), .onchip_osc_on_q(onchip_osc_on_q),
		.main_osc_run_q(main_osc_run_q), .pll_on_q(pll_on_q), .stop_mode_q(stop_mode_q),
		.wdt_onchip_q(wdt_onchip_q), .wait_allowed_q(wait_allowed_q), .osc_irq_q(osc_irq_q)
	);

	// ************
	// clock, oscillator and watchers
	// ************
	always #20 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (osc_run && osc_cnt == 0) begin
			main_osc_in <= ~main_osc_in;
			osc_cnt <= $urandom % 3;
		end else if (osc_cnt > 0) begin
			osc_cnt <= osc_cnt - 1;
		end
		if (osc_irq_q === 1'b1) irq_count++;
		rd_seen <= rd;
		if (rd_seen === 1'b1) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata_q", exp_v, rdata_q)
		end
	end

	// ************
	// tasks
	// ************
	task automatic test_done();
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk_sys);
		rd <= 1'b0;
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_irq(input int n);
		int i;
		for (i = 0; i < 60 && irq_count < n; i++) @(posedge clk_sys);
		if (irq_count < n) begin
			fail_count++;
			$display("mismatch osc_irq_q expected %0d seen %0d", n, irq_count);
			test_done();
		end
	endtask

	initial begin
		repeat (50000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end

	// ************
	// main sequence
	// ************
	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		det_resetn = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		main_osc_in = 1'b0;
		ext_clock_mode = 1'b0;
		fail_count = 0;
		checked = 0;
		irq_count = 0;
		osc_cnt = 0;
		osc_run = 1'b1;
		rd_seen = 1'b0;
		void'($urandom(34737));
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		settle();
		`CHK("cpu_src_q", 2'h0, cpu_src_q)
		`CHK("cpu_div_q", 3'h3, cpu_div_q)
		`CHK("onchip_osc_on_q", 1'h0, onchip_osc_on_q)
		rd_reg(css_pkg::ADDR_CLK_CTL0, css_pkg::RST_CLK_CTL0);
		rd_reg(css_pkg::ADDR_CLK_CTL1, {css_pkg::RST_CPU_DIV, css_pkg::RST_CLK_CTL1[5:0]});
		rd_reg(css_pkg::ADDR_PLL_CTL, css_pkg::RST_PLL_CTL);
		rd_reg(4'h7 + 4'($urandom % 9), 8'h00);
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h00);
		rd_reg(css_pkg::ADDR_CLK_CTL1, {css_pkg::RST_CPU_DIV, css_pkg::RST_CLK_CTL1[5:0]});
		wr_reg(css_pkg::ADDR_PROTECT, 8'h03);
		// main stop forces divide-by-8 and high drive
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h00);
		wr_reg(css_pkg::ADDR_CLK_CTL0, 8'h08);
		settle();
		`CHK("cpu_div_q", 3'h0, cpu_div_q)
		wr_reg(css_pkg::ADDR_CLK_CTL0, 8'h28);
		rd_reg(css_pkg::ADDR_CLK_CTL0, 8'h68);
		rd_reg(css_pkg::ADDR_CLK_CTL1, 8'h20);
		settle();
		`CHK("cpu_div_q", 3'h3, cpu_div_q)
		`CHK("main_osc_run_q", 1'h0, main_osc_run_q)
		ext_clock_mode <= 1'b1;
		settle();
		`CHK("main_osc_run_q", 1'h1, main_osc_run_q)
		// sub clock selected at once; external clock then stops with main stop
		wr_reg(css_pkg::ADDR_CLK_CTL0, 8'ha8);
		settle();
		`CHK("main_osc_run_q", 1'h0, main_osc_run_q)
		`CHK("cpu_src_q", 2'h1, cpu_src_q)
		ext_clock_mode <= 1'b0;
		wr_reg(css_pkg::ADDR_CLK_CTL0, 8'h08);
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h20);
		// one-time multiplier
		wr_reg(css_pkg::ADDR_PLL_CTL, 8'h03);
		wr_reg(css_pkg::ADDR_PLL_CTL, 8'h05);
		rd_reg(css_pkg::ADDR_PLL_CTL, 8'h03);
		wr_reg(css_pkg::ADDR_PLL_CTL, 8'h84);
		settle();
		`CHK("pll_on_q", 1'h1, pll_on_q)
		rd_reg(css_pkg::ADDR_PLL_CTL, 8'h83);
		wr_reg(css_pkg::ADDR_PLL_CTL, 8'h03);
		settle();
		`CHK("pll_on_q", 1'h0, pll_on_q)
		// stop detection with fallback
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h81);
		settle();
		osc_run <= 1'b0;
		wait_irq(1);
		settle();
		`CHK("cpu_src_q", 2'h2, cpu_src_q)
		`CHK("onchip_osc_on_q", 1'h1, onchip_osc_on_q)
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8f);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8f);
		osc_run <= 1'b1;
		repeat (40) @(posedge clk_sys);
		`CHK("irq count", 1, irq_count)
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h87);
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h87);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h87);
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h83);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h83);
		osc_run <= 1'b0;
		wait_irq(2);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8f);
		// detection reset keeps enable, select, action
		@(posedge clk_sys);
		det_resetn <= 1'b0;
		@(posedge clk_sys);
		det_resetn <= 1'b1;
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8b);
		osc_run <= 1'b1;
		wait_irq(3);
		// pll source: interrupt without fallback
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h81);
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h22);
		osc_run <= 1'b0;
		wait_irq(4);
		settle();
		`CHK("cpu_src_q", 2'h3, cpu_src_q)
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8d);
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h87);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h8f);
		osc_run <= 1'b1;
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h20);
		settle();
		`CHK("cpu_src_q", 2'h2, cpu_src_q)
		// watchdog source blocks stop request
		wr_reg(css_pkg::ADDR_PROC_M2, 8'h04);
		settle();
		`CHK("wdt_onchip_q", 1'h1, wdt_onchip_q)
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h82);
		wr_reg(css_pkg::ADDR_CLK_CTL1, 8'h21);
		settle();
		`CHK("stop_mode_q", 1'h0, stop_mode_q)
		rd_reg(css_pkg::ADDR_CLK_CTL1, 8'h20);
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h83);
		// clock-change lock
		wr_reg(css_pkg::ADDR_PROC_M2, 8'h06);
		settle();
		`CHK("wait_allowed_q", 1'h0, wait_allowed_q)
		wr_reg(css_pkg::ADDR_PROC_M2, 8'h04);
		rd_reg(css_pkg::ADDR_PROC_M2, 8'h06);
		wr_reg(css_pkg::ADDR_OSC_DET, 8'h82);
		rd_reg(css_pkg::ADDR_OSC_DET, 8'h83);
		wr_reg(css_pkg::ADDR_PLL_CTL, 8'h83);
		settle();
		`CHK("pll_on_q", 1'h0, pll_on_q)
		`CHK("pending reads", 0, exp_q.size())
		test_done();
	end
endmodule // tb
`default_nettype wire
